//--- dpdcm_params.svh
// Offsets, field positions, widths and timing counts of the converter front end.
// Assumes inclusion by the package and design files by bare name.
`ifndef DPDCM_PARAMS_SVH
`define DPDCM_PARAMS_SVH
`define DPDCM_ADDR_W        12
`define DPDCM_CTRL_OFF      12'h000
`define DPDCM_STATUS_OFF    12'h004
`define DPDCM_PERIOD_OFF    12'h008
`define DPDCM_WORD_OFF      12'h00C
`define DPDCM_CTRL_CAPTURE  0
`define DPDCM_CTRL_DRAIN    1
`define DPDCM_ST_LOCK       0
`define DPDCM_ST_ACTIVE     1
`define DPDCM_ST_RANGE_LO   2
`define DPDCM_ST_LEVEL_LO   4
`define DPDCM_ST_OVERFLOW   9
`define DPDCM_WORD_W        10
`define DPDCM_MAJOR_N       31
`define DPDCM_MINOR_N       15
`define DPDCM_STEER_W       47
`define DPDCM_CNT_W         16
`define DPDCM_FIFO_DEPTH    16
`define DPDCM_LOCK_TOL      16'h0001
`define DPDCM_PCLK_MHZ      20
`define DPDCM_MAX_MSPS      300
`define DPDCM_UPDATE_CYCLES ((`DPDCM_PCLK_MHZ + `DPDCM_MAX_MSPS - 1) / `DPDCM_MAX_MSPS)
`endif

//--- dpdcm_pkg.sv
// Types shared by the converter front end modules.
// Assumes dpdcm_params.svh is on the include path.
`include "dpdcm_params.svh"
package dpdcm_pkg;
    typedef enum logic [1:0] {DPDCM_LOOP_IDLE, DPDCM_LOOP_TRACK, DPDCM_LOOP_LOCKED} dpdcm_loop_type;
    typedef logic [`DPDCM_WORD_W-1:0]  dpdcm_word_type;
    typedef logic [`DPDCM_STEER_W-1:0] dpdcm_steer_type;
endpackage : dpdcm_pkg

//--- dpdcm_fifo_if.sv
// Valid/ready carrier between the output latch and the word buffer.
// Assumes both ends run on pclk.
interface dpdcm_fifo_if #(parameter int W = 10, parameter int LW = 5);
    logic [W-1:0]  wr_data;
    logic          wr_valid;
    logic          wr_ready;
    logic [W-1:0]  rd_data;
    logic          rd_valid;
    logic          rd_ready;
    logic [LW-1:0] level;
    modport fill  (output wr_data, wr_valid, rd_ready, input wr_ready, rd_data, rd_valid, level);
    modport store (input wr_data, wr_valid, rd_ready, output wr_ready, rd_data, rd_valid, level);
endinterface : dpdcm_fifo_if

//--- dpdcm_fifo.sv
// Word buffer between the output latch and the segment decoder.
// Assumes a single pclk domain and a clock enable that freezes it.
`include "dpdcm_params.svh"
module dpdcm_fifo
    import dpdcm_pkg::*;
#(
    parameter int WIDTH = `DPDCM_WORD_W,
    parameter int DEPTH = `DPDCM_FIFO_DEPTH,
    parameter int LW    = $clog2(DEPTH + 1)
)(
    input  wire logic  pclk,
    input  wire logic  presetn,
    input  wire logic  ce,
    dpdcm_fifo_if.store bus
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [LW-1:0]    level;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [LW-1:0]    next_level;
    logic             push;
    logic             pop;

    assign bus.wr_ready = (level != LW'(DEPTH));
    assign bus.rd_valid = (level != '0);
    assign bus.rd_data  = mem[rd_ptr];
    assign bus.level    = level;
    assign push         = bus.wr_valid & bus.wr_ready;
    assign pop          = bus.rd_valid & bus.rd_ready;

    always_comb
    begin
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_level  = LW'(level + LW'(push) - LW'(pop));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end
        else if (ce)
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            level  <= next_level;
        end
    end

    // Storage has no reset; a slot is only popped after a push has written it
    always_ff @(posedge pclk)
    begin
        if (ce && push)
        begin
            mem[wr_ptr] <= bus.wr_data;
        end
    end

    a_level_bound: assert property (@(posedge pclk) disable iff (!presetn)
        level <= LW'(DEPTH))
        else $error("buffer level above depth");
endmodule : dpdcm_fifo

//--- dpdcm_seg_decoder.sv
// Segment decoder: one word to registered steering controls for both outputs.
// Assumes words arrive at most once per pclk cycle.
`include "dpdcm_params.svh"
module dpdcm_seg_decoder
    import dpdcm_pkg::*;
(
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            ce,
    input  wire logic            load,
    input  wire dpdcm_word_type  word,
    output dpdcm_steer_type      true_steer,
    output dpdcm_steer_type      comp_steer
);
    dpdcm_steer_type           next_true;
    logic [`DPDCM_MAJOR_N-1:0] minor_all;

    function automatic logic [`DPDCM_MAJOR_N-1:0] thermo(input logic [4:0] n);
        logic [`DPDCM_MAJOR_N-1:0] t;
        t = '0;
        for (int i = 0; i < `DPDCM_MAJOR_N; i++)
            t[i] = (5'(i) < n);
        return t;
    endfunction : thermo

    always_comb
    begin
        minor_all = thermo({1'b0, word[4:1]});
        next_true = true_steer;
        if (load)
        begin
            next_true = {thermo(word[9:5]),
                         minor_all[`DPDCM_MINOR_N-1:0],
                         word[0]};
        end
    end

    // Complement is derived from the same bit, so each source has one home
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            true_steer <= '0;
            comp_steer <= '1;
        end
        else if (ce)
        begin
            true_steer <= next_true;
            comp_steer <= ~next_true;
        end
    end

    a_steer_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
        (true_steer ^ comp_steer) == '1)
        else $error("source steered to both or neither output");
    a_full_scale: assert property (@(posedge pclk) disable iff (!presetn)
        ce && load && word == 10'h3FF |=> true_steer == '1 && comp_steer == '0)
        else $error("full code did not steer all sources to true output");
    a_segment_count: assert property (@(posedge pclk) disable iff (!presetn)
        ce && load |=> $countones(true_steer[46:16]) == $past(word[9:5])
                    && $countones(true_steer[15:1]) == $past(word[4:1])
                    && true_steer[0] == $past(word[0]))
        else $error("segment decode count wrong");
endmodule : dpdcm_seg_decoder

//--- dpdcm_top.sv
// Dual-port converter front end in multiplier mode, with APB control and status.
// Assumes ext_clk, the data ports and straps come from pins and are asynchronous.
`include "dpdcm_params.svh"
module dpdcm_top
    import dpdcm_pkg::*;
// Behaviour
// - With the multiplier active a mid-period strobe doubles the update rate of the output latch.
// - The multiplier supply pin being powered selects multiplier-active operation.
// - Both ports are presented together and captured on the same rising ext_clk edge.
// - The lock indicator shows the loop's lock result and is high when locked.
// - Range selects high,low give a prescale of 1, 2, 4 or 8 for 00, 01, 10, 11.
// - Upper five bits drive 31 major sources, next four 15 minor, last bit one binary source.
// - Every source is steered to exactly one of the two complementary outputs.
// - Latches and decoding accept one new word every update cycle up to the top rate.
// - On each ext_clk rising edge the old second-port word moves to the output latch.
// - Half a measured period after each edge the first-port word moves to the output latch.
// - An all-ones word steers every source to the true output.
#(
    parameter int WORD_W     = `DPDCM_WORD_W,
    parameter int FIFO_DEPTH = `DPDCM_FIFO_DEPTH,
    parameter int CNT_W      = `DPDCM_CNT_W
)(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     ce,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`DPDCM_ADDR_W-1:0] paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     ext_clk,
    input  wire logic [WORD_W-1:0]        port_one_data,
    input  wire logic [WORD_W-1:0]        port_two_data,
    input  wire logic                     multiplier_supply_pin,
    input  wire logic                     divider_reset,
    input  wire logic                     range_select_low,
    input  wire logic                     range_select_high,
    output logic                          loop_lock_indicator,
    output dpdcm_steer_type               true_current_output,
    output dpdcm_steer_type               complement_current_output
);
    localparam int LW = $clog2(FIFO_DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    // Pin synchronisers
    logic              ext_s1;
    logic              ext_s2;
    logic              ext_s3;
    logic [WORD_W-1:0] p1_s1;
    logic [WORD_W-1:0] p1_s2;
    logic [WORD_W-1:0] p2_s1;
    logic [WORD_W-1:0] p2_s2;
    logic              sup_s1;
    logic              sup_s2;
    logic [1:0]        rng_s1;
    logic [1:0]        rng_s2;

    // Loop model
    dpdcm_loop_type    loop_state;
    dpdcm_loop_type    next_loop_state;
    logic [CNT_W-1:0]  period_cnt;
    logic [CNT_W-1:0]  next_period_cnt;
    logic [CNT_W-1:0]  period;
    logic [CNT_W-1:0]  next_period;
    logic [CNT_W-1:0]  ref_period;
    logic [CNT_W-1:0]  next_ref_period;
    logic [CNT_W-1:0]  half_cnt;
    logic [CNT_W-1:0]  next_half_cnt;
    logic [3:0]        cmp_cnt;
    logic [3:0]        next_cmp_cnt;
    logic [CNT_W-1:0]  diff;
    logic              edge_q;
    logic              active;
    logic              mid_fire;
    logic              next_lock;

    // Data path
    logic [WORD_W-1:0] port1_latch;
    logic [WORD_W-1:0] next_port1_latch;
    logic [WORD_W-1:0] port2_latch;
    logic [WORD_W-1:0] next_port2_latch;
    logic [WORD_W-1:0] out_word;
    logic [WORD_W-1:0] next_out_word;
    logic              overflow;
    logic              next_overflow;
    logic              upd_edge;
    logic              upd;
    logic              stall;
    logic [WORD_W-1:0] upd_word;

    // Register file
    logic              ctrl_capture;
    logic              ctrl_drain;
    logic              next_ctrl_capture;
    logic              next_ctrl_drain;
    logic [31:0]       next_prdata;
    logic              next_pslverr;
    logic              hit;
    logic              wr_access;
    logic              ovf_clear;
    logic [31:0]       rd_mux;

    dpdcm_fifo_if #(.W(WORD_W), .LW(LW)) fifo_bus ();

    function automatic logic [3:0] ratio_of(input logic [1:0] sel);
        return 4'h1 << sel;
    endfunction : ratio_of

    // divider_reset is deliberately unused in multiplier-active operation
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            p1_s1  <= '0;
            p1_s2  <= '0;
            p2_s1  <= '0;
            p2_s2  <= '0;
            sup_s1 <= 1'b0;
            sup_s2 <= 1'b0;
            rng_s1 <= 2'h0;
            rng_s2 <= 2'h0;
        end
        else if (ce)
        begin
            ext_s1 <= ext_clk;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            p1_s1  <= port_one_data;
            p1_s2  <= p1_s1;
            p2_s1  <= port_two_data;
            p2_s2  <= p2_s1;
            sup_s1 <= multiplier_supply_pin;
            sup_s2 <= sup_s1;
            rng_s1 <= {range_select_high, range_select_low};
            rng_s2 <= rng_s1;
        end
    end

    assign edge_q   = ext_s2 & ~ext_s3;
    assign active   = sup_s2;
    assign mid_fire = active && loop_state != DPDCM_LOOP_IDLE && !edge_q
                      && half_cnt == CNT_W'(1);
    assign diff     = (period_cnt > ref_period) ? CNT_W'(period_cnt - ref_period)
                                                : CNT_W'(ref_period - period_cnt);

    // Phase detector compares once every prescaled group of reference edges
    always_comb
    begin
        next_loop_state = loop_state;
        next_period_cnt = period_cnt;
        next_period     = period;
        next_ref_period = ref_period;
        next_half_cnt   = half_cnt;
        next_cmp_cnt    = cmp_cnt;
        if (!active)
        begin
            next_loop_state = DPDCM_LOOP_IDLE;
            next_period_cnt = '0;
            next_half_cnt   = '0;
            next_cmp_cnt    = 4'h0;
        end
        else if (edge_q)
        begin
            next_period     = period_cnt;
            next_period_cnt = CNT_W'(1);
            next_half_cnt   = (loop_state == DPDCM_LOOP_IDLE) ? '0 : (period_cnt >> 1);
            if (cmp_cnt >= ratio_of(rng_s2) - 4'h1)
            begin
                next_cmp_cnt    = 4'h0;
                next_ref_period = period_cnt;
                case (loop_state)
                    DPDCM_LOOP_IDLE:   next_loop_state = DPDCM_LOOP_TRACK;
                    DPDCM_LOOP_TRACK:  if (diff <= `DPDCM_LOCK_TOL)
                                           next_loop_state = DPDCM_LOOP_LOCKED;
                    DPDCM_LOOP_LOCKED: if (diff > `DPDCM_LOCK_TOL)
                                           next_loop_state = DPDCM_LOOP_TRACK;
                    default:           next_loop_state = DPDCM_LOOP_IDLE;
                endcase
            end
            else
            begin
                next_cmp_cnt = 4'(cmp_cnt + 4'h1);
            end
        end
        else
        begin
            // A stopped reference clock drops the loop out of lock
            if (period_cnt != CNT_MAX)
                next_period_cnt = CNT_W'(period_cnt + 1'b1);
            else
                next_loop_state = DPDCM_LOOP_IDLE;
            if (half_cnt != '0)
                next_half_cnt = CNT_W'(half_cnt - 1'b1);
        end
        next_lock = active && next_loop_state == DPDCM_LOOP_LOCKED;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            loop_state          <= DPDCM_LOOP_IDLE;
            period_cnt          <= '0;
            period              <= '0;
            ref_period          <= '0;
            half_cnt            <= '0;
            cmp_cnt             <= 4'h0;
            loop_lock_indicator <= 1'b0;
        end
        else if (ce)
        begin
            loop_state          <= next_loop_state;
            period_cnt          <= next_period_cnt;
            period              <= next_period;
            ref_period          <= next_ref_period;
            half_cnt            <= next_half_cnt;
            cmp_cnt             <= next_cmp_cnt;
            loop_lock_indicator <= next_lock;
        end
    end

    // A full buffer holds every latch, so no word is half moved
    assign upd_edge = edge_q && active && ctrl_capture;
    assign upd      = upd_edge || (mid_fire && ctrl_capture);
    assign upd_word = upd_edge ? port2_latch : port1_latch;
    assign stall    = upd && !fifo_bus.wr_ready;

    assign fifo_bus.wr_valid = upd;
    assign fifo_bus.wr_data  = upd_word;
    assign fifo_bus.rd_ready = ctrl_drain;

    always_comb
    begin
        next_port1_latch = port1_latch;
        next_port2_latch = port2_latch;
        next_out_word    = out_word;
        if (upd && !stall)
        begin
            next_out_word = upd_word;
            if (upd_edge)
            begin
                next_port1_latch = p1_s2;
                next_port2_latch = p2_s2;
            end
        end
        next_overflow = stall || (overflow && !ovf_clear);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port1_latch <= '0;
            port2_latch <= '0;
            out_word    <= '0;
            overflow    <= 1'b0;
        end
        else if (ce)
        begin
            port1_latch <= next_port1_latch;
            port2_latch <= next_port2_latch;
            out_word    <= next_out_word;
            overflow    <= next_overflow;
        end
    end

    dpdcm_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH), .LW(LW)) u_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .bus     (fifo_bus.store)
    );

    dpdcm_seg_decoder u_decoder (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .load       (fifo_bus.rd_valid && fifo_bus.rd_ready),
        .word       (fifo_bus.rd_data),
        .true_steer (true_current_output),
        .comp_steer (complement_current_output)
    );

    // APB slave, zero wait states: data is prepared in the setup cycle
    assign hit = paddr == `DPDCM_CTRL_OFF || paddr == `DPDCM_STATUS_OFF
              || paddr == `DPDCM_PERIOD_OFF || paddr == `DPDCM_WORD_OFF;
    assign wr_access = psel && penable && pwrite && pready && hit;
    assign ovf_clear = wr_access && paddr == `DPDCM_STATUS_OFF
                       && pwdata[`DPDCM_ST_OVERFLOW];

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `DPDCM_CTRL_OFF:
            begin
                rd_mux[`DPDCM_CTRL_CAPTURE] = ctrl_capture;
                rd_mux[`DPDCM_CTRL_DRAIN]   = ctrl_drain;
            end
            `DPDCM_STATUS_OFF:
            begin
                rd_mux[`DPDCM_ST_LOCK]                        = loop_lock_indicator;
                rd_mux[`DPDCM_ST_ACTIVE]                      = active;
                rd_mux[`DPDCM_ST_RANGE_LO +: 2]               = rng_s2;
                rd_mux[`DPDCM_ST_LEVEL_LO +: LW]              = fifo_bus.level;
                rd_mux[`DPDCM_ST_OVERFLOW]                    = overflow;
            end
            `DPDCM_PERIOD_OFF: rd_mux[CNT_W-1:0]  = period;
            `DPDCM_WORD_OFF:   rd_mux[WORD_W-1:0] = out_word;
            default:           rd_mux = 32'h0000_0000;
        endcase
        next_prdata       = prdata;
        next_pslverr      = pslverr;
        next_ctrl_capture = ctrl_capture;
        next_ctrl_drain   = ctrl_drain;
        if (psel && !penable)
        begin
            next_prdata  = pwrite ? 32'h0000_0000 : rd_mux;
            next_pslverr = !hit;
        end
        if (wr_access && paddr == `DPDCM_CTRL_OFF)
        begin
            next_ctrl_capture = pwdata[`DPDCM_CTRL_CAPTURE];
            next_ctrl_drain   = pwdata[`DPDCM_CTRL_DRAIN];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata       <= 32'h0000_0000;
            pslverr      <= 1'b0;
            pready       <= 1'b0;
            ctrl_capture <= 1'b0;
            ctrl_drain   <= 1'b0;
        end
        else if (ce)
        begin
            prdata       <= next_prdata;
            pslverr      <= next_pslverr;
            pready       <= 1'b1;
            ctrl_capture <= next_ctrl_capture;
            ctrl_drain   <= next_ctrl_drain;
        end
    end

    sequence s_locked_edge;
        ce && edge_q && active && loop_state == DPDCM_LOOP_LOCKED
        && period_cnt >= CNT_W'(4) && period_cnt < CNT_W'(500);
    endsequence
    sequence s_mid_follows;
        ##[1:300] mid_fire;
    endsequence

    a_double_rate: assert property (@(posedge pclk) disable iff (!presetn)
        s_locked_edge and ##1 ce[*8] |-> s_mid_follows)
        else $error("no mid-period update after a locked edge");
    a_inactive_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !active |-> !upd)
        else $error("output latch moved with multiplier inactive");
    a_ports_same_edge: assert property (@(posedge pclk) disable iff (!presetn)
        ce && upd_edge && !stall |=> port1_latch == $past(p1_s2) && port2_latch == $past(p2_s2))
        else $error("ports not captured on the same edge");
    a_lock_output: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !active |=> !loop_lock_indicator)
        else $error("lock shown while multiplier inactive");
    a_prescale_span: assert property (@(posedge pclk) disable iff (!presetn)
        ce && active && edge_q && cmp_cnt >= ratio_of(rng_s2) - 4'h1
        |=> cmp_cnt == 4'h0 && ref_period == $past(period_cnt))
        else $error("edge group longer than prescale ratio");
    a_second_to_output: assert property (@(posedge pclk) disable iff (!presetn)
        ce && upd_edge && !stall |=> out_word == $past(port2_latch))
        else $error("edge did not move second port word out");
    a_first_at_half: assert property (@(posedge pclk) disable iff (!presetn)
        ce && mid_fire && ctrl_capture && !stall |=> out_word == $past(port1_latch))
        else $error("mid strobe did not move first port word out");
    a_stall_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ce && stall |=> $stable(port1_latch) && $stable(port2_latch) && overflow)
        else $error("latch changed while buffer full");
    a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && $past(presetn) |-> pready)
        else $error("access phase without ready");
endmodule : dpdcm_top

//--- dpdcm_source.sv
// Data source model: drives the reference clock and both data ports.
// Assumes pclk is the bench clock; the reference clock stands still while run is low.
module dpdcm_source
(
    input  wire logic       pclk,
    input  wire logic       run,
    input  wire logic [9:0] w1,
    input  wire logic [9:0] w2,
    output logic            ext_clk,
    output logic [9:0]      p1,
    output logic [9:0]      p2,
    output logic            div_rst
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial
    begin
        ext_clk = 1'b0;
        p1 = 10'h000;
        p2 = 10'h000;
        div_rst = 1'b0;
    end
    // Period of 16 pclk; range 01 selected by the bench for this band
    always @(posedge pclk)
    begin
        if (run)
        begin
            cnt <= (cnt == 7) ? 0 : cnt + 1;
            if (cnt == 7)
            begin
                ext_clk <= ~ext_clk;
                // New words at the falling edge keep them stable at the rising one
                if (ext_clk)
                begin
                    p1 <= w1;
                    p2 <= w2;
                end
            end
        end
    end
endmodule : dpdcm_source

//--- dpdcm_top_tb.sv
// Self-checking bench for the converter front end.
// Assumes the source model and the design files are compiled first.
module dpdcm_top_tb
    import dpdcm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic            pclk, presetn, psel, penable, pwrite, run, rsl, rsh, rerr, sup;
    logic            ext_clk, div_rst, pready, pslverr, lock;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata, rdata;
    logic [9:0]      w1, w2, p1, p2;
    dpdcm_steer_type t_out, c_out;
    int              num_errors = 0;
    int              n_compared = 0;
    dpdcm_top dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_clk(ext_clk), .port_one_data(p1), .port_two_data(p2),
        .multiplier_supply_pin(sup), .divider_reset(div_rst), .range_select_low(rsl),
        .range_select_high(rsh), .loop_lock_indicator(lock), .true_current_output(t_out),
        .complement_current_output(c_out));
    dpdcm_source src (.pclk(pclk), .run(run), .w1(w1), .w2(w2), .ext_clk(ext_clk), .p1(p1),
        .p2(p2), .div_rst(div_rst));
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait for ready
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task settle(input int n);
        int i;
        for (i = 0; i < 600 && $countones(t_out) != n; i++) @(posedge pclk);
    endtask : settle
    task t_regs;
        apb(1'b0, 12'h000, 32'h0);
        chk(rdata, 64'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rdata, 64'h6);
        apb(1'b0, 12'h010, 32'h0);
        chk(rerr, 64'h1);
        $display("registers done");
    endtask : t_regs
    task t_stream;
        int i;
        w1 <= 10'h3FF;
        w2 <= 10'h3FF;
        run <= 1'b1;
        apb(1'b1, 12'h000, 32'h3);
        for (i = 0; i < 3000 && lock !== 1'b1; i++) @(posedge pclk);
        chk(lock, 64'h1);
        settle(47);
        chk(t_out, 64'h7FFFFFFFFFFF);
        chk(c_out, 64'h0);
        w1 <= 10'h210;
        w2 <= 10'h210;
        settle(24);
        chk($countones(t_out), 64'h18);
        chk(t_out ^ c_out, 64'h7FFFFFFFFFFF);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rdata, 64'h210);
        $display("stream done");
    endtask : t_stream
    task t_order;
        w2 <= 10'h3FF;
        repeat (64) @(posedge pclk);
        // Edge word shows 4 pclk after the pin edge, mid word 12 after
        @(posedge ext_clk);
        repeat (6) @(posedge pclk);
        chk(t_out, 64'h7FFFFFFFFFFF);
        repeat (8) @(posedge pclk);
        chk($countones(t_out), 64'h18);
        apb(1'b0, 12'h008, 32'h0);
        chk(rdata, 64'h10);
        $display("order done");
    endtask : t_order
    task t_overflow;
        apb(1'b1, 12'h000, 32'h1);
        repeat (200) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0);
        chk(rdata, 64'h307);
        apb(1'b1, 12'h000, 32'h3);
        apb(1'b1, 12'h004, 32'h200);
        apb(1'b0, 12'h004, 32'h0);
        chk(rdata[9], 64'h0);
        $display("overflow done");
    endtask : t_overflow
    task t_inactive;
        sup <= 1'b0;
        repeat (40) @(posedge pclk);
        chk(lock, 64'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rdata, 64'h4);
        $display("inactive done");
    endtask : t_inactive
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial
    begin
        #(8000 * 50);
        num_errors++;
        test_done;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, run, rsh} = 6'h00;
        rsl = 1'b1;
        sup = 1'b1;
        {paddr, pwdata, w1, w2} = 64'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_regs;
        t_stream;
        t_order;
        t_overflow;
        t_inactive;
        test_done;
    end
endmodule : dpdcm_top_tb
